/* core/adcc_pkg.sv */
package adcc_pkg;

  // Register byte addresses on the APB slave
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CLKCFG = 12'h004;
  localparam logic [11:0] ADDR_PINSEL = 12'h008;
  localparam logic [11:0] ADDR_RES_HI = 12'h00c;
  localparam logic [11:0] ADDR_RES_LO = 12'h010;

  // Field positions
  localparam int START_POS = 7;
  localparam int BUSY_POS  = 6;
  localparam int POWER_POS = 6;
  localparam int REF_POS   = 5;
  localparam int FIXED_POS = 7;

  // Values after reset
  localparam logic       START_RST = 1'b0;
  localparam logic       BUSY_RST  = 1'b1;
  localparam logic [3:0] CHSEL_RST = 4'h0;
  localparam logic       POWER_RST = 1'b0;
  localparam logic       REF_RST   = 1'b0;
  localparam logic [2:0] DIV_RST   = 3'h0;
  localparam logic [7:0] PIN_RST   = 8'h00;
  localparam logic       FIXED_ONE = 1'b1;

  // Converter clock divider codes
  localparam logic [2:0] DIV_BY2  = 3'h0;
  localparam logic [2:0] DIV_BY8  = 3'h1;
  localparam logic [2:0] DIV_BY32 = 3'h2;
  localparam logic [2:0] DIV_BY1  = 3'h4;
  localparam logic [2:0] DIV_BY4  = 3'h5;
  localparam logic [2:0] DIV_BY16 = 3'h6;

  // Channel select codes and analog source index in the mux select
  localparam logic [3:0] CH_OPA1  = 4'h6;
  localparam logic [3:0] CH_OPA2  = 4'h7;
  localparam logic [3:0] CH_AN6   = 4'h8;
  localparam logic [3:0] CH_AN7   = 4'h9;
  localparam int         OPA1_IDX = 8;
  localparam int         OPA2_IDX = 9;
  localparam int         SRC_NUM  = 10;

  // Pin select mask of the narrow variant
  localparam logic [7:0] PIN_MASK_NARROW = 8'h3f;

  // Conversion length in converter clock cycles
  localparam logic [4:0] CONV_CYCLES = 5'h10;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_HOLD,
    SEQ_RUN
  } adcc_seq_state_t;

endpackage : adcc_pkg

/* core/adcc_conv_if.sv */
interface adcc_conv_if;
  logic [2:0] div_code;
  logic       power_off;
  logic       conv_tick;
  logic       start_level;
  logic       busy;
  logic       done;
  logic       hold_reset;

  modport divider (
    input  div_code,
    input  power_off,
    output conv_tick
  );

  modport seq (
    input  conv_tick,
    input  start_level,
    output busy,
    output done,
    output hold_reset
  );

  modport ctrl (
    output div_code,
    output power_off,
    output start_level,
    input  conv_tick,
    input  busy,
    input  done,
    input  hold_reset
  );
endinterface : adcc_conv_if

/* core/adcc_clk_div.sv */
module adcc_clk_div (
  // Clock and reset
  input wire logic     pclk,
  input wire logic     presetn,
  // Divider controls and tick
  adcc_conv_if.divider cif
);
  import adcc_pkg::*;

  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic       tick_reg;
  logic       tick_next;
  logic [4:0] ratio_m1;
  logic       div_valid;

  // Divide ratio minus one per code; undefined codes give no tick
  always_comb begin
    div_valid = 1'b1;
    case (cif.div_code)
      DIV_BY1:  ratio_m1 = 5'h00;
      DIV_BY2:  ratio_m1 = 5'h01;
      DIV_BY4:  ratio_m1 = 5'h03;
      DIV_BY8:  ratio_m1 = 5'h07;
      DIV_BY16: ratio_m1 = 5'h0f;
      DIV_BY32: ratio_m1 = 5'h1f;
      default: begin
        ratio_m1  = 5'h00;
        div_valid = 1'b0;
      end
    endcase
    if (!div_valid || cif.power_off) begin
      count_next = 5'h00;
      tick_next  = 1'b0;
    end else if (count_reg >= ratio_m1) begin
      count_next = 5'h00;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + 5'h01;
      tick_next  = 1'b0;
    end
  end

  // Divider state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 5'h00;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign cif.conv_tick = tick_reg;

  no_tick_undef_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!div_valid || cif.power_off) |=> !tick_reg)
    else $error("converter tick with undefined code or power off");

  div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && cif.div_code == DIV_BY2 && !cif.power_off)[*3]
      |-> tick_reg != $past(tick_reg))
    else $error("divide by two tick does not alternate");

endmodule : adcc_clk_div

/* core/adcc_conv_seq.sv */
module adcc_conv_seq (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Start level, tick and status
  adcc_conv_if.seq cif
);
  import adcc_pkg::*;

  adcc_seq_state_t state_reg;
  adcc_seq_state_t state_next;
  logic [4:0]      cnt_reg;
  logic [4:0]      cnt_next;
  logic            busy_reg;
  logic            busy_next;
  logic            done_reg;
  logic            done_next;
  logic            prev_reg;
  logic            rise;
  logic            hold_reg;
  logic            hold_next;

  // Start bit edge: a rise resets the converter, the fall launches it
  always_comb begin
    rise       = cif.start_level && !prev_reg;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    if (rise) begin
      state_next = SEQ_HOLD;
      busy_next  = 1'b1;
    end else begin
      case (state_reg)
        SEQ_HOLD: begin
          if (!cif.start_level) begin
            state_next = SEQ_RUN;
            cnt_next   = 5'h00;
          end
        end
        SEQ_RUN: begin
          if (cif.conv_tick) begin
            if (cnt_reg == CONV_CYCLES - 5'h01) begin
              state_next = SEQ_IDLE;
              busy_next  = 1'b0;
              done_next  = 1'b1;
            end else begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        default: begin
          state_next = SEQ_IDLE;
        end
      endcase
    end
    // Converter reset follows the hold state from a flop of its own
    hold_next = (state_next == SEQ_HOLD);
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SEQ_IDLE;
      cnt_reg   <= 5'h00;
      busy_reg  <= BUSY_RST;
      done_reg  <= 1'b0;
      prev_reg  <= START_RST;
      hold_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      prev_reg  <= cif.start_level;
      hold_reg  <= hold_next;
    end
  end

  assign cif.busy       = busy_reg;
  assign cif.done       = done_reg;
  assign cif.hold_reset = hold_reg;

  rise_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.start_level && !prev_reg) |=> busy_reg && cif.hold_reset)
    else $error("start rise did not hold converter in reset");

  fall_starts_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == SEQ_HOLD && !cif.start_level)
      |=> state_reg == SEQ_RUN && cnt_reg == 5'h00)
    else $error("start fall did not launch a conversion");

  end_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == SEQ_RUN && cif.conv_tick && !cif.start_level
      && cnt_reg == CONV_CYCLES - 5'h01)
      |=> done_reg && !busy_reg ##1 !done_reg)
    else $error("conversion end did not clear busy with one done pulse");

  run_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != SEQ_IDLE) |-> busy_reg)
    else $error("busy low during a conversion");

endmodule : adcc_conv_seq

/* core/adcc_top.sv */
module adcc_top #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  // System clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Conversion core
  input  wire logic [11:0]              conv_data,
  output logic                          conv_reset,
  output logic                          conv_clock_tick,
  output logic                          conv_done,
  output logic                          converter_power_off,
  output logic                          reference_select,
  // Analog routing and pins
  output logic [adcc_pkg::SRC_NUM-1:0]  source_select,
  output logic [7:0]                    analog_pin_enable,
  output logic [7:0]                    pullup_disconnect
);
  import adcc_pkg::*;

  adcc_conv_if cif ();

  // Register state
  logic              start_reg;
  logic              start_next;
  logic [3:0]        chsel_reg;
  logic [3:0]        chsel_next;
  logic              power_reg;
  logic              power_next;
  logic              ref_reg;
  logic              ref_next;
  logic [2:0]        div_reg;
  logic [2:0]        div_next;
  logic [7:0]        pin_reg;
  logic [7:0]        pin_next;
  logic [11:0]       result_reg;
  logic [11:0]       result_next;
  // Bus answer state
  logic              pready_reg;
  logic              pready_next;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  // Routing outputs
  logic [SRC_NUM-1:0] src_reg;
  logic [SRC_NUM-1:0] src_next;
  logic [7:0]        pullup_reg;
  // Decode helpers
  logic              access;
  logic              wr_en;
  logic              mapped;
  logic [7:0]        rdata;
  logic [3:0]        chsel_mask;
  logic [7:0]        pin_mask;
  logic [3:0]        chsel_eff;

  // Variant masks for channel and pin fields
  assign chsel_mask = WIDE_VARIANT ? 4'hf : 4'h7;
  assign pin_mask   = WIDE_VARIANT ? 8'hff : PIN_MASK_NARROW;
  assign chsel_eff  = chsel_reg & chsel_mask;

  // Submodules share the conversion interface
  assign cif.div_code    = div_reg;
  assign cif.power_off   = power_reg;
  assign cif.start_level = start_reg;

  // Converter clock divider
  adcc_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // Conversion sequencer
  adcc_conv_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // APB phase decode, one wait state on every access
  assign access = psel && penable;
  assign wr_en  = access && pready_reg && pwrite;

  // Address decode and read data
  always_comb begin
    mapped = 1'b1;
    rdata  = 8'h00;
    if (paddr == ADDR_CTRL) begin
      rdata            = {4'h0, chsel_eff};
      rdata[START_POS] = start_reg;
      rdata[BUSY_POS]  = cif.busy;
    end else if (paddr == ADDR_CLKCFG) begin
      rdata            = {5'h00, div_reg};
      rdata[FIXED_POS] = FIXED_ONE;
      rdata[POWER_POS] = power_reg;
      rdata[REF_POS]   = ref_reg;
    end else if (paddr == ADDR_PINSEL) begin
      rdata = pin_reg & pin_mask;
    end else if (paddr == ADDR_RES_HI) begin
      rdata = result_reg[11:4];
    end else if (paddr == ADDR_RES_LO) begin
      rdata = {result_reg[3:0], 4'h0};
    end else begin
      mapped = 1'b0;
    end
  end

  // Bus answer: ready in the second access cycle, data and error with it
  always_comb begin
    pready_next  = access && !pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (pready_next) begin
      prdata_next  = pwrite ? 32'h0000_0000 : {24'h00_0000, rdata};
      pslverr_next = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Software register writes; read-only fields ignore writes
  always_comb begin
    start_next  = start_reg;
    chsel_next  = chsel_reg;
    power_next  = power_reg;
    ref_next    = ref_reg;
    div_next    = div_reg;
    pin_next    = pin_reg;
    result_next = result_reg;
    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        start_next = pwdata[START_POS];
        chsel_next = pwdata[3:0] & chsel_mask;
      end else if (paddr == ADDR_CLKCFG) begin
        power_next = pwdata[POWER_POS];
        ref_next   = pwdata[REF_POS];
        div_next   = pwdata[2:0];
      end else if (paddr == ADDR_PINSEL) begin
        pin_next = pwdata[7:0] & pin_mask;
      end
    end
    if (cif.done) begin
      result_next = conv_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg  <= START_RST;
      chsel_reg  <= CHSEL_RST;
      power_reg  <= POWER_RST;
      ref_reg    <= REF_RST;
      div_reg    <= DIV_RST;
      pin_reg    <= PIN_RST;
      result_reg <= 12'h000;
    end else begin
      start_reg  <= start_next;
      chsel_reg  <= chsel_next;
      power_reg  <= power_next;
      ref_reg    <= ref_next;
      div_reg    <= div_next;
      pin_reg    <= pin_next;
      result_reg <= result_next;
    end
  end

  // Analog source decode: one source at most, none for unused codes
  always_comb begin
    src_next = '0;
    if (chsel_eff <= 4'h5) begin
      src_next[chsel_eff[2:0]] = 1'b1;
    end else if (chsel_eff == CH_OPA1) begin
      src_next[OPA1_IDX] = 1'b1;
    end else if (chsel_eff == CH_OPA2) begin
      src_next[OPA2_IDX] = 1'b1;
    end else if (chsel_eff == CH_AN6) begin
      src_next[6] = 1'b1;
    end else if (chsel_eff == CH_AN7) begin
      src_next[7] = 1'b1;
    end
  end

  // Routing and pin function flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg    <= '0;
      pullup_reg <= PIN_RST;
    end else begin
      src_reg    <= src_next;
      pullup_reg <= pin_next;
    end
  end

  // Outputs, each straight from a flop
  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign conv_reset          = cif.hold_reset;
  assign conv_clock_tick     = cif.conv_tick;
  assign conv_done           = cif.done;
  assign converter_power_off = power_reg;
  assign reference_select    = ref_reg;
  assign source_select       = src_reg;
  assign analog_pin_enable   = pin_reg;
  assign pullup_disconnect   = pullup_reg;

  opa_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chsel_eff == CH_OPA1 && $stable(chsel_eff))
      |=> src_reg[OPA1_IDX] && $countones(src_reg) == 1)
    else $error("op-amp 1 output not routed alone");

  wide_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chsel_eff == CH_AN7) |=> src_reg[7] && $countones(src_reg) == 1)
    else $error("code nine did not route input seven");

  one_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    $countones(src_reg) <= 1)
    else $error("more than one analog source connected");

  pin_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_PINSEL)
      |=> analog_pin_enable == ($past(pwdata[7:0]) & pin_mask))
    else $error("pin select write not applied");

  pullup_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    pullup_disconnect == analog_pin_enable)
    else $error("pull-up not removed with analog pin");

  narrow_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    !WIDE_VARIANT |-> analog_pin_enable[7:6] == 2'b00)
    else $error("unimplemented pin select bits set");

  power_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_CLKCFG)
      |=> converter_power_off == $past(pwdata[POWER_POS])
        && reference_select == $past(pwdata[REF_POS]))
    else $error("power or reference bit not applied");

  cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_reg && !pwrite && paddr == ADDR_CLKCFG)
      |=> pready && prdata[7] && prdata[4:3] == 2'b00)
    else $error("clock config fixed bits read wrong");

  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_reg && !pwrite && paddr == ADDR_CTRL)
      |=> prdata[BUSY_POS] == $past(cif.busy) && prdata[5:4] == 2'b00
        && (WIDE_VARIANT || !prdata[3]))
    else $error("control register read wrong");

  result_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> result_reg == $past(conv_data))
    else $error("result not captured at conversion end");

  ctrl_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_CTRL)
      |=> start_reg == $past(pwdata[START_POS])
        && chsel_reg == ($past(pwdata[3:0]) & chsel_mask))
    else $error("control register write not applied");

  div_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_CLKCFG) |=> div_reg == $past(pwdata[2:0]))
    else $error("clock divider code not applied");

  res_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_reg && !pwrite && paddr == ADDR_RES_LO)
      |=> prdata[3:0] == 4'h0 && prdata[7:4] == $past(result_reg[3:0]))
    else $error("result low byte read wrong");

  src_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chsel_eff > CH_AN7) |=> src_reg == '0)
    else $error("unused channel code connected a source");

endmodule : adcc_top

/* verif/adcc_core_model.sv */
module adcc_core_model (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Controls from the block
  input  wire logic                        conv_reset,
  input  wire logic                        conv_done,
  input  wire logic [adcc_pkg::SRC_NUM-1:0] source_select,
  // Sample level chosen by the bench
  input  wire logic [7:0]                  level,
  // Result towards the block
  output logic      [11:0]                 conv_data
);
  import adcc_pkg::*;

  logic       flip_reg;
  logic       flip_next;
  logic [3:0] src_idx;
  logic [11:0] sample;

  // Index of the one connected source, all ones when none is
  always_comb begin
    src_idx = 4'hf;
    for (int i = 0; i < SRC_NUM; i++) begin
      if (source_select[i]) src_idx = i[3:0];
    end
    flip_next = ~flip_reg;
  end

  // Toggles every cycle so stale data is inverted in every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flip_reg <= 1'b0;
    else flip_reg <= flip_next;
  end

  // Result only holds outside reset in the cycle of conversion end
  assign sample    = {level, src_idx};
  assign conv_data = (conv_done && !conv_reset) ? sample
                     : sample ^ {12{flip_reg}};
endmodule : adcc_core_model

/* verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;

  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite;
  logic [11:0]       paddr, conv_data;
  logic [31:0]       pwdata, prdata, rdv;
  logic              pready, pslverr, errv;
  logic              conv_reset, conv_clock_tick, conv_done;
  logic              converter_power_off, reference_select;
  logic [SRC_NUM-1:0] source_select;
  logic [7:0]        analog_pin_enable, pullup_disconnect, level, v;
  int                n_errors = 0;
  int                total_checks = 0;
  int                nt;

  always #5 pclk = ~pclk;

  adcc_top u_adcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_data(conv_data), .conv_reset(conv_reset),
    .conv_clock_tick(conv_clock_tick), .conv_done(conv_done),
    .converter_power_off(converter_power_off),
    .reference_select(reference_select), .source_select(source_select),
    .analog_pin_enable(analog_pin_enable),
    .pullup_disconnect(pullup_disconnect));

  adcc_core_model u_adcc_core_model (.pclk(pclk), .presetn(presetn),
    .conv_reset(conv_reset), .conv_done(conv_done),
    .source_select(source_select), .level(level), .conv_data(conv_data));

  // Verdict and end of run
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin
        n_errors++;
        $display("MISMATCH at %0t: no bus answer", $time);
        conclude();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rdv, errv);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, rdv, errv);
    check(rdv, {24'h0, e}, "register read");
    check(errv, 1'b0, "read error flag");
  endtask : rchk

  // Settle, then count converter clock ticks over a window
  task automatic ticks(input int cyc, output int n);
    repeat (32) @(posedge pclk);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (conv_clock_tick === 1'b1) n++;
    end
  endtask : ticks

  function automatic logic [9:0] exp_src(input logic [3:0] c);
    if (c < 4'h6) return 10'h1 << c;
    if (c == CH_OPA1) return 10'h1 << OPA1_IDX;
    if (c == CH_OPA2) return 10'h1 << OPA2_IDX;
    if (c == CH_AN6) return 10'h040;
    if (c == CH_AN7) return 10'h080;
    return 10'h0;
  endfunction : exp_src

  function automatic int ratio(input logic [2:0] c);
    case (c)
      DIV_BY2: return 2;
      DIV_BY8: return 8;
      DIV_BY32: return 32;
      DIV_BY1: return 1;
      DIV_BY4: return 4;
      DIV_BY16: return 16;
      default: return 0;
    endcase
  endfunction : ratio

  // Full conversion, optionally restarted while running
  task automatic conv(input logic [3:0] ch, input logic [2:0] dc,
                      input bit abort);
    int n, k;
    logic [3:0] ix;
    ix = ch < 4'h6 ? ch : (ch == 4'h6 ? 4'h8 : ch == 4'h7 ? 4'h9 : ch - 4'h2);
    wr(ADDR_CLKCFG, {5'h0, dc});
    level <= 8'($urandom);
    wr(ADDR_CTRL, {4'h8, ch});
    repeat (2) @(posedge pclk);
    check(conv_reset, 1'b1, "converter held");
    rchk(ADDR_CTRL, {4'hc, ch});
    wr(ADDR_CTRL, {4'h0, ch});
    if (abort) begin
      repeat (3) @(posedge pclk);
      wr(ADDR_CTRL, {4'h8, ch});
      repeat (2) @(posedge pclk);
      check(conv_reset, 1'b1, "restart holds");
      wr(ADDR_CTRL, {4'h0, ch});
    end
    n = 0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      if (conv_done !== 1'b1 && conv_clock_tick === 1'b1
          && conv_reset === 1'b0) n++;
      if (k > 3000) begin
        n_errors++;
        $display("MISMATCH at %0t: conversion never ended", $time);
        conclude();
      end
    end while (conv_done !== 1'b1);
    check(n, CONV_CYCLES, "conversion length");
    repeat (2) @(posedge pclk);
    rchk(ADDR_CTRL, {4'h0, ch});
    rchk(ADDR_RES_HI, level);
    rchk(ADDR_RES_LO, {ix, 4'h0});
  endtask : conv

  initial begin
    void'($urandom(62));
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; level = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Values after reset
    rchk(ADDR_CTRL, 8'h40);
    rchk(ADDR_CLKCFG, 8'h80);
    rchk(ADDR_PINSEL, 8'h00);
    $display("reset values test done");
    // Pin select, corners then random
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      wr(ADDR_PINSEL, v);
      repeat (2) @(posedge pclk);
      check(analog_pin_enable, v, "analog pins");
      check(pullup_disconnect, v, "pull-ups off");
      rchk(ADDR_PINSEL, v);
    end
    $display("pin select test done");
    // Every divider code, random reference, then power off
    for (int c = 0; c < 8; c++) begin
      v = {2'b00, 1'($urandom), 2'b00, 3'(c)};
      wr(ADDR_CLKCFG, v);
      rchk(ADDR_CLKCFG, v | 8'h80);
      check(reference_select, v[REF_POS], "reference");
      ticks(64, nt);
      check(nt, ratio(3'(c)) ? 64 / ratio(3'(c)) : 0, "ticks");
    end
    wr(ADDR_CLKCFG, 8'h44);
    ticks(64, nt);
    check(nt, 0, "ticks when off");
    check(converter_power_off, 1'b1, "power off pin");
    $display("clock config test done");
    // Conversions over several dividers, one restarted
    conv(4'($urandom % 10), DIV_BY2, 1'b0);
    conv(4'($urandom % 10), DIV_BY8, 1'b1);
    conv(4'($urandom % 10), DIV_BY1, 1'b0);
    conv(4'($urandom % 10), DIV_BY4, 1'b0);
    $display("conversion test done");
    // All channel codes, with busy and unused bits written high
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CTRL, 8'h70 | 8'(c));
      repeat (2) @(posedge pclk);
      check(source_select, exp_src(4'(c)), "source");
      rchk(ADDR_CTRL, 8'(c));
    end
    $display("channel test done");
    // Unmapped access, then power down while idle
    apb(1'b0, 12'h020, 32'h0, rdv, errv);
    check(errv, 1'b1, "unmapped error");
    wr(ADDR_CLKCFG, 8'h40);
    repeat (2) @(posedge pclk);
    check(converter_power_off, 1'b1, "idle power down");
    $display("refusal and power test done");
    conclude();
  end
endmodule : tb_top
